// File: src/csc_regs.svh
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// Register offsets (word index on the plain register port).
`define CSC_ADDR_STATUS 4'h0
`define CSC_ADDR_CORE_CTRL 4'h1
`define CSC_ADDR_WINDOW_PAGE 4'h2
`define CSC_ADDR_INT_CTRL_ONE 4'h3
`define CSC_ADDR_LOOP_COUNT 4'h4

// Status register fields.
`define CSC_SR_HALF_CARRY 8
`define CSC_SR_PRIO_HI 7
`define CSC_SR_PRIO_LO 5
`define CSC_SR_LOOP_RUN 4
`define CSC_SR_NEG 3
`define CSC_SR_WRAP 2
`define CSC_SR_ZERO 1
`define CSC_SR_CARRY 0
`define CSC_SR_WRITE_MASK 16'h01EF

// Core control fields.
`define CSC_CC_PRIO_MSB 3
`define CSC_CC_WINDOW_EN 2

// Interrupt control one field.
`define CSC_IC1_NEST_DIS 15

// Reset values.
`define CSC_SR_RESET 16'h0000
`define CSC_CC_RESET 16'h0000
`define CSC_PAGE_RESET 8'h00
`define CSC_PRIO_DISABLE 3'h7

// Divide timing: iterations inside the loop and total instruction cycles.
`define CSC_DIV_ITER 5'h11
`define CSC_DIV_CYCLES 19

// Address geometry.
`define CSC_WINDOW_BASE_BIT 15
`define CSC_PAGE_WORD_SHIFT 14

`endif

// File: src/csc_pkg.sv
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_OP_ADD = 2'b00,
    CSC_OP_SUB = 2'b01,
    CSC_OP_LOGIC = 2'b10,
    CSC_OP_SHIFT = 2'b11
  } csc_op_e;

  typedef enum logic [1:0] {
    CSC_LOOP_IDLE = 2'b00,
    CSC_LOOP_RUN = 2'b01,
    CSC_LOOP_DIV = 2'b10
  } csc_loop_e;

  typedef logic [15:0] csc_word_t;
  typedef logic [3:0] csc_addr_t;
endpackage

// File: src/csc_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "csc_regs.svh"

module csc_core
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire csc_pkg::csc_addr_t reg_addr_i,
  input wire csc_pkg::csc_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output csc_pkg::csc_word_t reg_rdata_o,
  // ALU operation and flag update
  input wire logic alu_valid_i,
  input wire csc_pkg::csc_op_e alu_op_i,
  input wire logic alu_byte_i,
  input wire csc_pkg::csc_word_t alu_a_i,
  input wire csc_pkg::csc_word_t alu_b_i,
  input wire logic [4:0] alu_shamt_i,
  input wire logic alu_shleft_i,
  output csc_pkg::csc_word_t alu_result_o,
  // Multiplier
  input wire logic mul_a_signed_i,
  input wire logic mul_b_signed_i,
  output logic [31:0] mul_product_o,
  // Hardware loop and divide
  input wire logic loop_start_i,
  input wire logic [13:0] loop_count_i,
  input wire logic div_start_i,
  input wire logic irq_take_i,
  output logic loop_running_o,
  output logic div_done_o,
  // Priority state
  output logic user_irq_disable_o,
  output logic [3:0] cpu_priority_o,
  // Data-space window
  input wire logic [15:0] data_addr_i,
  output logic window_hit_o,
  output logic [23:0] window_prog_addr_o
);
  import csc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic half_carry_q;
  logic [2:0] prio_q;
  logic neg_q;
  logic wrap_q;
  logic zero_q;
  logic carry_q;
  logic prio_msb_q;
  logic window_en_q;
  logic [7:0] window_page_q;
  logic nest_dis_q;
  logic [13:0] loop_cnt_q;
  csc_loop_e loop_state_q;
  csc_loop_e loop_state_d;
  logic [4:0] div_iter_q;

  // ----------------------------------------------------------------
  // Flag arithmetic
  // ----------------------------------------------------------------
  function automatic logic [16:0] add_ext(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin);
    add_ext = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
  endfunction

  function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b,
                                         input logic cin);
    nib_add = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  function automatic logic [8:0] byte_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    byte_add = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // Subtraction is a + ~b + 1, so carry out is the inverted borrow.
  wire is_sub = (alu_op_i == CSC_OP_SUB);
  wire is_arith = (alu_op_i == CSC_OP_ADD) || is_sub;
  wire [15:0] b_eff = is_sub ? ~alu_b_i : alu_b_i;
  wire [16:0] sum_w = add_ext(alu_a_i, b_eff, is_sub);
  wire [8:0] sum_b = byte_add(alu_a_i[7:0], b_eff[7:0], is_sub);
  wire [4:0] nib_sum = nib_add(alu_a_i[3:0], b_eff[3:0], is_sub);
  wire [8:0] low_sum = byte_add(alu_a_i[7:0], b_eff[7:0], is_sub);

  // Shifter: whole operand in one cycle, distance up to 31.
  wire [31:0] shl_w = {16'h0000, alu_a_i} << alu_shamt_i;
  wire [15:0] shr_w = alu_a_i >> alu_shamt_i;
  wire [15:0] shift_res = alu_shleft_i ? shl_w[15:0] : shr_w;

  wire [15:0] logic_res = alu_a_i & alu_b_i;
  // Results are one 16-bit working-register word wide.
  wire [15:0] result_w = is_arith ? sum_w[15:0] :
                         (alu_op_i == CSC_OP_SHIFT) ? shift_res : logic_res;

  wire msb_res = alu_byte_i ? result_w[7] : result_w[15];
  wire res_nonzero = alu_byte_i ? (result_w[7:0] != 8'h00) : (result_w != 16'h0000);
  wire carry_out = alu_byte_i ? sum_b[8] : sum_w[16];
  wire half_out = alu_byte_i ? nib_sum[4] : low_sum[8];
  wire a_msb = alu_byte_i ? alu_a_i[7] : alu_a_i[15];
  wire b_msb = alu_byte_i ? b_eff[7] : b_eff[15];
  wire wrap_out = is_arith && (a_msb == b_msb) && (msb_res != a_msb);

  // ----------------------------------------------------------------
  // Multiplier
  // ----------------------------------------------------------------
  // Each operand is extended to 17 bits so that mixed sign products fit one array.
  wire signed [16:0] mul_a = {mul_a_signed_i & alu_a_i[15], alu_a_i};
  wire signed [16:0] mul_b = {mul_b_signed_i & alu_b_i[15], alu_b_i};
  wire signed [33:0] mul_full = mul_a * mul_b;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_sr = reg_wr_i && (reg_addr_i == `CSC_ADDR_STATUS);
  wire wr_cc = reg_wr_i && (reg_addr_i == `CSC_ADDR_CORE_CTRL);
  wire wr_pg = reg_wr_i && (reg_addr_i == `CSC_ADDR_WINDOW_PAGE);
  wire wr_ic = reg_wr_i && (reg_addr_i == `CSC_ADDR_INT_CTRL_ONE);
  wire flag_upd = alu_valid_i && !wr_sr;
  wire [15:0] sr_view = {7'h00, half_carry_q, prio_q, loop_state_q != CSC_LOOP_IDLE,
                         neg_q, wrap_q, zero_q, carry_q};
  wire [15:0] cc_view = {12'h000, prio_msb_q, window_en_q, 2'b00};
  wire [15:0] rd_mux =
    (reg_addr_i == `CSC_ADDR_STATUS) ? sr_view :
    (reg_addr_i == `CSC_ADDR_CORE_CTRL) ? cc_view :
    (reg_addr_i == `CSC_ADDR_WINDOW_PAGE) ? {8'h00, window_page_q} :
    (reg_addr_i == `CSC_ADDR_INT_CTRL_ONE) ? {nest_dis_q, 15'h0000} :
    (reg_addr_i == `CSC_ADDR_LOOP_COUNT) ? {2'b00, loop_cnt_q} : 16'h0000;

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // A register write wins over an ALU update in the same cycle; software owns it then.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      {half_carry_q, neg_q, wrap_q, zero_q, carry_q} <= 5'h00;
      prio_q <= 3'h0;
    end
    else if (wr_sr)
    begin
      half_carry_q <= reg_wdata_i[`CSC_SR_HALF_CARRY];
      neg_q <= reg_wdata_i[`CSC_SR_NEG];
      wrap_q <= reg_wdata_i[`CSC_SR_WRAP];
      zero_q <= reg_wdata_i[`CSC_SR_ZERO];
      carry_q <= reg_wdata_i[`CSC_SR_CARRY];
      if (!nest_dis_q)
      begin
        prio_q <= reg_wdata_i[`CSC_SR_PRIO_HI:`CSC_SR_PRIO_LO];
      end
    end
    else if (flag_upd)
    begin
      neg_q <= msb_res;
      if (res_nonzero)
      begin
        zero_q <= 1'b0;
      end
      if (is_arith)
      begin
        carry_q <= carry_out;
        half_carry_q <= half_out;
        wrap_q <= wrap_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core control, page and nesting control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prio_msb_q <= 1'b0;
      window_en_q <= 1'b0;
      window_page_q <= `CSC_PAGE_RESET;
      nest_dis_q <= 1'b0;
    end
    else
    begin
      if (wr_cc)
      begin
        window_en_q <= reg_wdata_i[`CSC_CC_WINDOW_EN];
        if (!reg_wdata_i[`CSC_CC_PRIO_MSB])
        begin
          prio_msb_q <= 1'b0;
        end
      end
      if (wr_pg)
      begin
        window_page_q <= reg_wdata_i[7:0];
      end
      if (wr_ic)
      begin
        nest_dis_q <= reg_wdata_i[`CSC_IC1_NEST_DIS];
      end
    end
  end

  assign cpu_priority_o = {prio_msb_q, prio_q};
  assign user_irq_disable_o = prio_msb_q || (prio_q == `CSC_PRIO_DISABLE);

  // ----------------------------------------------------------------
  // Hardware loop and divide sequencing
  // ----------------------------------------------------------------
  // The loop count lives in a register, so taking an interrupt only pauses
  // the iteration; nothing is discarded.
  always_comb
  begin
    loop_state_d = loop_state_q;
    case (loop_state_q)
      CSC_LOOP_IDLE:
      begin
        if (div_start_i)
        begin
          loop_state_d = CSC_LOOP_DIV;
        end
        else if (loop_start_i)
        begin
          loop_state_d = CSC_LOOP_RUN;
        end
      end
      CSC_LOOP_RUN:
      begin
        if (!irq_take_i && (loop_cnt_q == 14'h0000))
        begin
          loop_state_d = CSC_LOOP_IDLE;
        end
      end
      CSC_LOOP_DIV:
      begin
        if (!irq_take_i && (div_iter_q == 5'h00))
        begin
          loop_state_d = CSC_LOOP_IDLE;
        end
      end
      default:
      begin
        loop_state_d = CSC_LOOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      loop_state_q <= CSC_LOOP_IDLE;
      loop_cnt_q <= 14'h0000;
      div_iter_q <= 5'h00;
    end
    else
    begin
      loop_state_q <= loop_state_d;
      if ((loop_state_q == CSC_LOOP_IDLE) && div_start_i)
      begin
        div_iter_q <= `CSC_DIV_ITER - 5'h01;
      end
      else if ((loop_state_q == CSC_LOOP_IDLE) && loop_start_i)
      begin
        loop_cnt_q <= loop_count_i;
      end
      else if ((loop_state_q == CSC_LOOP_RUN) && !irq_take_i && (loop_cnt_q != 14'h0000))
      begin
        loop_cnt_q <= loop_cnt_q - 14'h0001;
      end
      else if ((loop_state_q == CSC_LOOP_DIV) && !irq_take_i && (div_iter_q != 5'h00))
      begin
        div_iter_q <= div_iter_q - 5'h01;
      end
    end
  end

  assign loop_running_o = (loop_state_q != CSC_LOOP_IDLE);

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic div_done_q;
  logic [15:0] result_q;
  logic [31:0] product_q;
  logic win_hit_q;
  logic [23:0] win_addr_q;
  logic [15:0] rdata_q;

  // Window: when enabled, data addresses with bit 15 set go to program space at page * 32K words.
  wire win_hit_d = window_en_q && data_addr_i[`CSC_WINDOW_BASE_BIT];
  wire [23:0] win_addr_d = {1'b0, window_page_q, 15'h0000} |
                           {9'h000, data_addr_i[14:0]};

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_q <= 16'h0000;
      result_q <= 16'h0000;
      product_q <= 32'h0000_0000;
      div_done_q <= 1'b0;
      win_hit_q <= 1'b0;
      win_addr_q <= 24'h000000;
    end
    else
    begin
      rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
      result_q <= result_w;
      product_q <= mul_full[31:0];
      div_done_q <= (loop_state_q == CSC_LOOP_DIV) && (loop_state_d == CSC_LOOP_IDLE);
      win_hit_q <= win_hit_d;
      win_addr_q <= win_hit_d ? win_addr_d : 24'h000000;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign alu_result_o = result_q;
  assign mul_product_o = product_q;
  assign div_done_o = div_done_q;
  assign window_hit_o = win_hit_q;
  assign window_prog_addr_o = win_addr_q;
endmodule

`default_nettype wire

// File: verification/csc_core_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "csc_regs.svh"

module csc_props
  import csc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire csc_pkg::csc_addr_t reg_addr_i,
  input wire csc_pkg::csc_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire csc_pkg::csc_word_t reg_rdata_o,
  // Loop, priority and window
  input wire logic loop_start_i,
  input wire logic div_start_i,
  input wire logic loop_running_o,
  input wire logic user_irq_disable_o,
  input wire logic [3:0] cpu_priority_o,
  input wire logic [15:0] data_addr_i,
  input wire logic window_hit_o,
  input wire logic [23:0] window_prog_addr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // Shadow copies of control bits that never reach a port.
  logic nest_q, win_q;
  wire logic nest_d = (reg_wr_i && reg_addr_i == `CSC_ADDR_INT_CTRL_ONE) ? reg_wdata_i[15] : nest_q;
  wire logic win_d = (reg_wr_i && reg_addr_i == `CSC_ADDR_CORE_CTRL) ? reg_wdata_i[2] : win_q;
  wire logic hit_d = win_q && data_addr_i[15];
  always_ff @(posedge clk_i)
  begin
    nest_q <= srst_i ? 1'h0 : nest_d;
    win_q <= srst_i ? 1'h0 : win_d;
  end

  property p_irq_off;
    user_irq_disable_o == (cpu_priority_o[3] || cpu_priority_o[2:0] == 3'h7);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq disable wrong");
  property p_st_rd;
    reg_rd_i && reg_addr_i == `CSC_ADDR_STATUS |=> reg_rdata_o[15:9] == 7'h00
      && reg_rdata_o[4] == $past(loop_running_o)
      && {1'h0, reg_rdata_o[7:5]} == ($past(cpu_priority_o) & 4'h7);
  endproperty
  a_st_rd: assert property (p_st_rd) else $error("status read wrong");
  property p_cc_rd;
    reg_rd_i && reg_addr_i == `CSC_ADDR_CORE_CTRL |=> reg_rdata_o[15:4] == 12'h000
      && reg_rdata_o[1:0] == 2'h0 && {reg_rdata_o[3], 3'h0} == ($past(cpu_priority_o) & 4'h8);
  endproperty
  a_cc_rd: assert property (p_cc_rd) else $error("core control read wrong");
  property p_msb;
    !cpu_priority_o[3] |=> !cpu_priority_o[3];
  endproperty
  a_msb: assert property (p_msb) else $error("priority msb was set");
  property p_nest;
    nest_q |=> (cpu_priority_o & 4'h7) == ($past(cpu_priority_o) & 4'h7);
  endproperty
  a_nest: assert property (p_nest) else $error("priority changed while locked");
  property p_div;
    div_start_i && !loop_running_o |=> loop_running_o [*8];
  endproperty
  a_div: assert property (p_div) else $error("divide not running");
  property p_loop;
    loop_start_i && !div_start_i && !loop_running_o |=> loop_running_o;
  endproperty
  a_loop: assert property (p_loop) else $error("loop not running");
  property p_win;
    1'h1 |=> window_hit_o == $past(hit_d);
  endproperty
  a_win: assert property (p_win) else $error("window hit wrong");
  property p_wadr;
    window_hit_o |-> !window_prog_addr_o[23]
      && {1'h0, window_prog_addr_o[14:0]} == ($past(data_addr_i) & 16'h7FFF);
  endproperty
  a_wadr: assert property (p_wadr) else $error("window address wrong");
endmodule

bind csc_core csc_props u_props (.*);

`default_nettype wire

// File: verification/cpu_status_core_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "csc_regs.svh"

module cpu_status_core_control_tb
  import csc_pkg::*;
;
  logic clk_i = 1'h0, srst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0, alu_valid_i = 1'h0;
  logic alu_byte_i = 1'h0, alu_shleft_i = 1'h0, mul_a_signed_i = 1'h0, mul_b_signed_i = 1'h0;
  logic loop_start_i = 1'h0, div_start_i = 1'h0, irq_take_i = 1'h0, nest;
  logic loop_running_o, div_done_o, user_irq_disable_o, window_hit_o;
  csc_addr_t reg_addr_i = '0;
  csc_word_t reg_wdata_i = '0, alu_a_i = '0, alu_b_i = '0, reg_rdata_o, alu_result_o, st, v;
  csc_op_e alu_op_i = CSC_OP_ADD;
  logic [4:0] alu_shamt_i = '0;
  logic [13:0] loop_count_i = '0;
  logic [15:0] data_addr_i = '0;
  logic [31:0] mul_product_o, x, seed = 32'hDA0CDCB5;
  logic [3:0] cpu_priority_o;
  logic [23:0] window_prog_addr_o;
  int fail_count = 0, tests_run = 0;
  localparam logic [31:0] CORN [4] = '{32'h0, 32'h7FFF0001, 32'h00000001, 32'h000F0001};

  always #2.5 clk_i = ~clk_i;
  csc_core dut (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Gives {half carry, negative, overflow, zero, carry, result}; subtract adds the inverse.
  function automatic logic [20:0] arith(input logic sb, input logic byt, input csc_word_t a,
                                        input csc_word_t b);
    csc_word_t c;
    logic [16:0] s;
    logic [8:0] s8;
    logic [4:0] s4;
    c = sb ? ~b : b;
    s = {1'h0, a} + {1'h0, c} + 17'(sb);
    s8 = {1'h0, a[7:0]} + {1'h0, c[7:0]} + 9'(sb);
    s4 = {1'h0, a[3:0]} + {1'h0, c[3:0]} + 5'(sb);
    if (byt)
      return {s4[4], s8[7], a[7] == c[7] && s8[7] != a[7], s8[7:0] == 8'h00, s8[8], 8'h00, s8[7:0]};
    return {s8[8], s[15], a[15] == c[15] && s[15] != a[15], s[15:0] == 16'h0, s[16], s[15:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input csc_addr_t a, input csc_word_t d);
    @(posedge clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'h1, a, d};
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
  endtask

  task automatic rd(input csc_addr_t a, output csc_word_t d);
    @(posedge clk_i);
    {reg_rd_i, reg_addr_i} <= {1'h1, a};
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    #1 d = reg_rdata_o;
  endtask

  task automatic wst(input csc_word_t d);
    wr(`CSC_ADDR_STATUS, d);
    st = (d & 16'h01EF & (nest ? 16'h010F : 16'hFFFF)) | (st & (nest ? 16'h00E0 : 16'h0));
  endtask

  task automatic alu(input csc_op_e op, input logic byt, input csc_word_t a, input csc_word_t b);
    logic [4:0] f, sh;
    csc_word_t r;
    x = rnd();
    sh = 5'(x[7:3] % 5'h11);
    @(posedge clk_i);
    {alu_shleft_i, mul_a_signed_i, mul_b_signed_i} <= x[2:0];
    {alu_valid_i, alu_op_i, alu_byte_i, alu_a_i, alu_b_i, alu_shamt_i} <= {1'h1, op, byt, a, b, sh};
    @(posedge clk_i);
    alu_valid_i <= 1'h0;
    #1;
    chk(mul_product_o, $signed({x[1] & a[15], a}) * $signed({x[0] & b[15], b}));
    {f, r} = arith(op == CSC_OP_SUB, byt, a, b);
    if (op == CSC_OP_LOGIC)
      r = a & b;
    if (op == CSC_OP_SHIFT)
      r = x[2] ? a << sh : a >> sh;
    chk(alu_result_o & (byt ? 16'hFF : 16'hFFFF), r);
    if (op[1])
      f = {st[8], r[15], st[2], r == 16'h0, st[0]};
    st = {7'h00, f[4], st[7:4], f[3], f[2], f[1] & st[1], f[0]};
    rd(`CSC_ADDR_STATUS, v);
    chk(v, st);
  endtask

  // A pause stretches the run by one cycle per cycle that it is held.
  task automatic run_loop(input logic dv, input logic [13:0] n, input logic [1:0] k);
    logic [7:0] cnt, dn;
    cnt = 8'h00;
    dn = 8'h00;
    @(posedge clk_i);
    {loop_start_i, div_start_i, loop_count_i} <= {~dv, dv, n};
    for (int t = 1; t < 41; t++)
    begin
      @(posedge clk_i);
      {loop_start_i, div_start_i, irq_take_i} <= {2'h0, t <= k};
      #1;
      cnt = cnt + 8'(loop_running_o);
      dn = dn + (div_done_o ? 8'(t) : 8'h00);
    end
    chk(cnt, dv ? 17 + k : n + 1 + k);
    chk(dn, dv ? 18 + k : 0);
    rd(`CSC_ADDR_LOOP_COUNT, v);
    chk(v, 16'h0);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    nest = 1'h0;
    st = 16'h0;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'h0;
    rd(`CSC_ADDR_STATUS, v);
    chk(v, 16'h0);
    rd(`CSC_ADDR_CORE_CTRL, v);
    chk(v, 16'h0);
    rd(4'hF, v);
    chk(v, 16'h0);
    $display("reset test done");
    for (int i = 0; i < 24; i++)
    begin
      if (i % 8 == 0)
      begin
        nest = i == 8;
        wr(`CSC_ADDR_INT_CTRL_ONE, {nest, 15'h0});
      end
      wst(i == 0 ? 16'hFFFF : 16'(rnd()));
      rd(`CSC_ADDR_STATUS, v);
      chk(v, st);
      chk({user_irq_disable_o, cpu_priority_o}, {st[7:5] == 3'h7, 1'h0, st[7:5]});
    end
    wr(`CSC_ADDR_CORE_CTRL, 16'hFFFF);
    rd(`CSC_ADDR_CORE_CTRL, v);
    chk(v, 16'h0004);
    $display("status test done");
    for (int j = 0; j < 8; j++)
    begin
      v = 16'(rnd());
      wr(`CSC_ADDR_WINDOW_PAGE, v);
      wr(`CSC_ADDR_CORE_CTRL, {13'h0, j[0], 2'h0});
      x = rnd();
      @(posedge clk_i);
      data_addr_i <= {j[1], x[14:0]};
      @(posedge clk_i);
      #1;
      chk({window_hit_o, window_prog_addr_o}, j[0] & j[1] ? {2'h2, v[7:0], x[14:0]} : 0);
      rd(`CSC_ADDR_WINDOW_PAGE, st);
      chk(st, {8'h00, v[7:0]});
    end
    $display("window test done");
    st = 16'h0;
    wst(16'h0002);
    for (int i = 0; i < 200; i++)
    begin
      x = rnd();
      if (i < 4)
        alu(i == 2 ? CSC_OP_SUB : CSC_OP_ADD, i == 3, CORN[i][31:16], CORN[i][15:0]);
      else
        alu(csc_op_e'(x[1:0]), x[1] ? 1'h0 : x[2], 16'(rnd()), 16'(rnd()));
    end
    $display("alu test done");
    for (int j = 0; j < 8; j++)
      run_loop(j[0], 14'(rnd() % 6), 2'(j >> 1));
    $display("loop test done");
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
endmodule

`default_nettype wire
